// ==== pfpc_defines.vh ====
// constants for the pin function and pad control block
`ifndef PFPC_DEFINES_VH
`define PFPC_DEFINES_VH

`define PFPC_NPINS        6
`define PFPC_ADDR_W       8

`define PFPC_OFS_SOPT     8'h00
`define PFPC_OFS_FRST     8'h04
`define PFPC_OFS_PULL     8'h08
`define PFPC_OFS_SLEW     8'h0C
`define PFPC_OFS_DRIVE    8'h10
`define PFPC_OFS_STATUS   8'h14

`define PFPC_BIT_RPE      0
`define PFPC_BIT_DPE      1
`define PFPC_BIT_FRST     0

`define PFPC_ST_BDM       0
`define PFPC_ST_PINRST    1
`define PFPC_ST_FRCRST    2
`define PFPC_ST_LVL_LO    8

`define PFPC_PIN_DBG      4
`define PFPC_PIN_RST      5
`define PFPC_NANA         4
`define PFPC_NTIMOUT      2

`define PFPC_PULL_RST     6'h00
`define PFPC_SLEW_RST     6'h10
`define PFPC_DRIVE_RST    6'h00

`define PFPC_RST_HOLD     4'h8
`define PFPC_BIT_CYC      5'h10
`define PFPC_ICS_MHZ      16
`define PFPC_BUS_MHZ      4

`define PFPC_SRC_POR      2'h0
`define PFPC_SRC_PIN      2'h1
`define PFPC_SRC_FRC      2'h2
`define PFPC_SRC_OTH      2'h3

`endif

// ==== pfpc_pad.v ====
// one pad: output enable, data and pull/slew/drive resolution
`timescale 1ns/1ns
module pfpc_pad (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire sys_rst,
  // owning function
  input  wire own_drive,
  input  wire own_data,
  input  wire own_analog,
  input  wire own_rise,
  input  wire force_pull,
  // per-pin control bits
  input  wire pull_bit,
  input  wire slew_bit,
  input  wire drive_bit,
  // pad side
  output reg  pad_out,
  output reg  pad_oe_n,
  output reg  pad_pull_en,
  output reg  pad_pull_dn,
  output reg  pad_slew_en,
  output reg  pad_drive_hi
);

  wire pull_w;

  // pull dropped while driven or analog, forced on for reset/debug functions
  assign pull_w = force_pull | (pull_bit & ~own_drive & ~own_analog);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out      <= 1'b0;
      pad_oe_n     <= 1'b1;
      pad_pull_en  <= 1'b0;
      pad_pull_dn  <= 1'b0;
      pad_slew_en  <= 1'b0;
      pad_drive_hi <= 1'b0;
    end else if (ce) begin
      if (sys_rst) begin
        pad_out      <= 1'b0;
        pad_oe_n     <= ~force_pull | 1'b1;
        pad_pull_en  <= force_pull;
        pad_pull_dn  <= 1'b0;
        pad_slew_en  <= 1'b0;
        pad_drive_hi <= 1'b0;
      end else begin
        pad_out      <= own_data;
        pad_oe_n     <= ~own_drive;
        pad_pull_en  <= pull_w;
        pad_pull_dn  <= pull_w & ~force_pull & own_rise;
        pad_slew_en  <= slew_bit & own_drive;
        pad_drive_hi <= drive_bit & own_drive;
      end
    end
  end

endmodule // pfpc_pad

// ==== pfpc_top.v ====
// pin function multiplexing, mode selection at reset and pad control
`timescale 1ns/1ns
`include "pfpc_defines.vh"
module pfpc_top #(
  parameter NPINS = `PFPC_NPINS
) (
  // apb clock, reset, enable
  input  wire             pclk,
  input  wire             presetn,
  input  wire             ce,
  // apb slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [31:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // port logic
  input  wire [NPINS-1:0] port_dir,
  input  wire [NPINS-1:0] port_data,
  output reg  [NPINS-1:0] port_in,
  // peripherals on pins 0..3
  input  wire [3:0]       kbd_en,
  input  wire [3:0]       kbd_rise,
  input  wire [3:0]       tim1_en,
  input  wire [1:0]       tim1_out_en,
  input  wire [1:0]       tim1_out,
  input  wire [3:0]       adc_en,
  input  wire [3:0]       ana2_en,
  // peripherals on pins 4 and 5
  input  wire             tim2_out_en,
  input  wire             tim2_out,
  input  wire             tim2_cap_en,
  input  wire             irq_en,
  input  wire             irq_rise,
  output reg              second_timer_capture_input,
  output reg              irq_level,
  // debug controller
  input  wire             bdc_drive_low,
  input  wire             bdc_speedup,
  output reg              bdc_bit_tick,
  output reg              background_debug_mode,
  // reset control
  input  wire             other_rst_req,
  output wire             sys_rst_n,
  // clock defaults
  output reg              clk_internal_sel,
  output reg  [3:0]       bus_clk_div,
  // pads
  input  wire [NPINS-1:0] pad_in,
  output wire [NPINS-1:0] pad_out,
  output wire [NPINS-1:0] pad_oe_n,
  output wire [NPINS-1:0] pad_pull_en,
  output wire [NPINS-1:0] pad_pull_dn,
  output wire [NPINS-1:0] pad_slew_en,
  output wire [NPINS-1:0] pad_drive_hi
);

  localparam DBG = `PFPC_PIN_DBG;
  localparam RST = `PFPC_PIN_RST;
  localparam [31:0] BUS_DIV = `PFPC_ICS_MHZ / `PFPC_BUS_MHZ;

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg             reset_pin_enable;
  reg             debug_pin_enable;
  reg [NPINS-1:0] pull_reg;
  reg [NPINS-1:0] slew_reg;
  reg [NPINS-1:0] drive_reg;
  reg             pin_rst_seen_reg;
  reg             frc_rst_seen_reg;
  reg [3:0]       rst_cnt_reg;
  reg [1:0]       rst_src_reg;
  reg [4:0]       bit_cnt_reg;

  wire            sys_rst;
  wire            last_rst;
  wire            ms_low;
  wire            pin_rst_req;
  wire            frc_req;

  // apb decode
  function map_hit;
    input [31:0] a;
    begin
      if (a[31:`PFPC_ADDR_W] != 24'h00_0000)
        map_hit = 1'b0;
      else if (a[7:0] == `PFPC_OFS_SOPT)
        map_hit = 1'b1;
      else if (a[7:0] == `PFPC_OFS_FRST)
        map_hit = 1'b1;
      else if (a[7:0] == `PFPC_OFS_PULL)
        map_hit = 1'b1;
      else if (a[7:0] == `PFPC_OFS_SLEW)
        map_hit = 1'b1;
      else if (a[7:0] == `PFPC_OFS_DRIVE)
        map_hit = 1'b1;
      else if (a[7:0] == `PFPC_OFS_STATUS)
        map_hit = 1'b1;
      else
        map_hit = 1'b0;
    end
  endfunction

  function is_reg;
    input [31:0] a;
    input [7:0]  ofs;
    begin
      is_reg = (a[31:`PFPC_ADDR_W] == 24'h00_0000) && (a[7:0] == ofs);
    end
  endfunction

  wire acc    = psel & penable & ce;
  wire wr_acc = acc & pwrite & map_hit(paddr);

  assign pready  = ce;
  assign pslverr = psel & penable & ~map_hit(paddr);

  assign frc_req = wr_acc & is_reg(paddr, `PFPC_OFS_FRST) & pwdata[`PFPC_BIT_FRST];

  ////////////////////////////////////////////////////////////////////////
  // reset stretch and mode selection

  assign sys_rst     = (rst_cnt_reg != 4'h0);
  assign sys_rst_n   = ~sys_rst;
  assign last_rst    = (rst_cnt_reg == 4'h1);
  assign ms_low      = ~pad_in[DBG];
  // pin heard only once its pullup is on, so a floating pin cannot trip it
  assign pin_rst_req = reset_pin_enable & pad_pull_en[RST] & ~pad_in[RST];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_reg           <= `PFPC_RST_HOLD;
      rst_src_reg           <= `PFPC_SRC_POR;
      background_debug_mode <= 1'b0;
      reset_pin_enable      <= 1'b0;
      pin_rst_seen_reg      <= 1'b0;
      frc_rst_seen_reg      <= 1'b0;
    end else if (ce) begin
      if (pin_rst_req) begin
        rst_cnt_reg      <= `PFPC_RST_HOLD;
        rst_src_reg      <= `PFPC_SRC_PIN;
        pin_rst_seen_reg <= 1'b1;
        frc_rst_seen_reg <= 1'b0;
      end else if (frc_req) begin
        rst_cnt_reg      <= `PFPC_RST_HOLD;
        rst_src_reg      <= `PFPC_SRC_FRC;
        frc_rst_seen_reg <= 1'b1;
        pin_rst_seen_reg <= 1'b0;
      end else if (other_rst_req) begin
        rst_cnt_reg      <= `PFPC_RST_HOLD;
        rst_src_reg      <= `PFPC_SRC_OTH;
        pin_rst_seen_reg <= 1'b0;
        frc_rst_seen_reg <= 1'b0;
      end else if (sys_rst) begin
        rst_cnt_reg <= rst_cnt_reg - 4'h1;
      end
      // mode caught at the rising edge of internal reset
      if (last_rst && !pin_rst_req && !frc_req && !other_rst_req) begin
        if ((rst_src_reg == `PFPC_SRC_POR) || (rst_src_reg == `PFPC_SRC_FRC))
          background_debug_mode <= ms_low;
        else
          background_debug_mode <= 1'b0;
        if ((rst_src_reg == `PFPC_SRC_POR) && ms_low)
          reset_pin_enable <= 1'b1;
      end else if (!sys_rst && wr_acc && is_reg(paddr, `PFPC_OFS_SOPT) && pwdata[`PFPC_BIT_RPE]) begin
        reset_pin_enable <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software control registers

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_pin_enable <= 1'b1;
      pull_reg         <= `PFPC_PULL_RST;
      slew_reg         <= `PFPC_SLEW_RST;
      drive_reg        <= `PFPC_DRIVE_RST;
    end else if (ce) begin
      if (sys_rst) begin
        debug_pin_enable <= 1'b1;
        pull_reg         <= `PFPC_PULL_RST;
        slew_reg         <= `PFPC_SLEW_RST;
        drive_reg        <= `PFPC_DRIVE_RST;
      end else if (wr_acc) begin
        if (is_reg(paddr, `PFPC_OFS_SOPT))
          debug_pin_enable <= pwdata[`PFPC_BIT_DPE];
        else if (is_reg(paddr, `PFPC_OFS_PULL))
          pull_reg <= pwdata[NPINS-1:0];
        else if (is_reg(paddr, `PFPC_OFS_SLEW))
          slew_reg <= pwdata[NPINS-1:0];
        else if (is_reg(paddr, `PFPC_OFS_DRIVE))
          drive_reg <= pwdata[NPINS-1:0];
      end
    end
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      if (is_reg(paddr, `PFPC_OFS_SOPT))
        prdata <= {30'h0000_0000, debug_pin_enable, reset_pin_enable};
      else if (is_reg(paddr, `PFPC_OFS_PULL))
        prdata <= {{(32-NPINS){1'b0}}, pull_reg};
      else if (is_reg(paddr, `PFPC_OFS_SLEW))
        prdata <= {{(32-NPINS){1'b0}}, slew_reg};
      else if (is_reg(paddr, `PFPC_OFS_DRIVE))
        prdata <= {{(32-NPINS){1'b0}}, drive_reg};
      else if (is_reg(paddr, `PFPC_OFS_STATUS))
        prdata <= {{(24-NPINS){1'b0}}, pad_in, 5'h00,
                   frc_rst_seen_reg, pin_rst_seen_reg, background_debug_mode};
      else
        prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // function priority per pin

  reg [NPINS-1:0] own_drive;
  reg [NPINS-1:0] own_data;
  reg [NPINS-1:0] own_analog;
  reg [NPINS-1:0] own_rise;
  reg [NPINS-1:0] force_pull;
  integer         i;

  always @* begin
    own_drive  = {NPINS{1'b0}};
    own_data   = {NPINS{1'b0}};
    own_analog = {NPINS{1'b0}};
    own_rise   = {NPINS{1'b0}};
    force_pull = {NPINS{1'b0}};
    for (i = 0; i < `PFPC_NANA; i = i + 1) begin
      if (adc_en[i] || ana2_en[i]) begin
        own_analog[i] = 1'b1;
      end else if (tim1_en[i]) begin
        if (i < `PFPC_NTIMOUT) begin
          own_drive[i] = tim1_out_en[i];
          own_data[i]  = tim1_out[i];
        end
      end else if (kbd_en[i]) begin
        own_rise[i] = kbd_rise[i];
      end else begin
        own_drive[i] = port_dir[i];
        own_data[i]  = port_data[i];
      end
    end
    // debug pin: pseudo open drain with brief speedup pulses
    if (debug_pin_enable) begin
      own_drive[DBG]  = bdc_drive_low | bdc_speedup;
      own_data[DBG]   = bdc_speedup;
      force_pull[DBG] = 1'b1;
    end else if (tim2_out_en) begin
      own_drive[DBG] = 1'b1;
      own_data[DBG]  = tim2_out;
    end else begin
      own_drive[DBG] = port_dir[DBG];
      own_data[DBG]  = port_data[DBG];
    end
    // input-only pin
    if (reset_pin_enable) begin
      force_pull[RST] = 1'b1;
    end else if (irq_en) begin
      own_rise[RST] = irq_rise;
    end
  end

  // pin-level routing to functions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_in                    <= {NPINS{1'b0}};
      second_timer_capture_input <= 1'b0;
      irq_level                  <= 1'b0;
    end else if (ce) begin
      port_in                    <= pad_in & ~own_analog;
      second_timer_capture_input <= tim2_cap_en & ~reset_pin_enable & ~irq_en & pad_in[RST];
      irq_level                  <= irq_en & ~reset_pin_enable & pad_in[RST];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debug bit timing and clock defaults

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg      <= 5'h00;
      bdc_bit_tick     <= 1'b0;
      clk_internal_sel <= 1'b1;
      bus_clk_div      <= 4'h0;
    end else if (ce) begin
      if (sys_rst) begin
        clk_internal_sel <= 1'b1;
        bus_clk_div      <= BUS_DIV[3:0];
      end
      if (!debug_pin_enable || sys_rst) begin
        bit_cnt_reg  <= 5'h00;
        bdc_bit_tick <= 1'b0;
      end else if (bit_cnt_reg == `PFPC_BIT_CYC - 5'h01) begin
        bit_cnt_reg  <= 5'h00;
        bdc_bit_tick <= 1'b1;
      end else begin
        bit_cnt_reg  <= bit_cnt_reg + 5'h01;
        bdc_bit_tick <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pads

  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : pads
      pfpc_pad u_pad (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .sys_rst     (sys_rst),
        .own_drive   (own_drive[g]),
        .own_data    (own_data[g]),
        .own_analog  (own_analog[g]),
        .own_rise    (own_rise[g]),
        .force_pull  (force_pull[g]),
        .pull_bit    (pull_reg[g]),
        .slew_bit    (slew_reg[g]),
        .drive_bit   (drive_reg[g]),
        .pad_out     (pad_out[g]),
        .pad_oe_n    (pad_oe_n[g]),
        .pad_pull_en (pad_pull_en[g]),
        .pad_pull_dn (pad_pull_dn[g]),
        .pad_slew_en (pad_slew_en[g]),
        .pad_drive_hi(pad_drive_hi[g])
      );
    end
  endgenerate

endmodule // pfpc_top

// ==== pfpc_props.sv ====
// assertion checker for the pin function and pad control block
`timescale 1ns/1ns
module pfpc_props #(
  parameter NPINS = 6
) (
  // clock and reset
  input wire             pclk,
  input wire             presetn,
  input wire             ce,
  // function selects
  input wire [3:0]       kbd_en,
  input wire [3:0]       kbd_rise,
  input wire [3:0]       tim1_en,
  input wire [3:0]       adc_en,
  input wire [3:0]       ana2_en,
  input wire             tim2_cap_en,
  // observed outputs
  input wire             second_timer_capture_input,
  input wire             bdc_bit_tick,
  input wire             background_debug_mode,
  input wire             sys_rst_n,
  input wire             clk_internal_sel,
  input wire [3:0]       bus_clk_div,
  input wire [NPINS-1:0] pad_oe_n,
  input wire [NPINS-1:0] pad_pull_en,
  input wire [NPINS-1:0] pad_pull_dn
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_out_no_pull: assert property ((~pad_oe_n & pad_pull_en) == 0)
    else $error("pullup on while pad drives");
  a_analog_no_pull: assert property (ce && (adc_en[0] | ana2_en[0]) |=> !pad_pull_en[0] && pad_oe_n[0])
    else $error("analog pin has pullup or drive");
  a_rise_pulldown: assert property (ce && kbd_en[2] && kbd_rise[2] && !adc_en[2] && !ana2_en[2] && !tim1_en[2]
    |=> !pad_pull_en[2] || pad_pull_dn[2])
    else $error("rising edge keypad pull not down");
  a_mode_hold: assert property (sys_rst_n && $past(sys_rst_n) |-> $stable(background_debug_mode))
    else $error("mode changed outside reset");
  a_clk_default: assert property ($rose(sys_rst_n) |-> clk_internal_sel && bus_clk_div == 4'h4)
    else $error("clock defaults wrong after reset");
  a_reset_pads: assert property ($rose(sys_rst_n)
    |-> pad_oe_n[3:0] == 4'hf && pad_pull_en[3:0] == 4'h0 && pad_pull_en[4])
    else $error("pad defaults wrong after reset");
  a_cap_owner: assert property (ce && !tim2_cap_en |=> !second_timer_capture_input)
    else $error("capture input routed while not owner");
  a_bit_time: assert property (ce && bdc_bit_tick |=> (!bdc_bit_tick)[*8] ##1 (!bdc_bit_tick)[*7])
    else $error("debug bit time shorter than 16");
  ////////////////////////////////////////
  c_bdm_entry: cover property ($rose(sys_rst_n) && background_debug_mode);
  c_pulldown: cover property (pad_pull_en[2] && pad_pull_dn[2]);
  c_tick: cover property (bdc_bit_tick);
endmodule // pfpc_props

bind pfpc_top pfpc_props #(.NPINS(NPINS)) u_props (.*);

// ==== pfpc_board.sv ====
// board circuitry and debug pod model on the six pads
`timescale 1ns/1ns
module pfpc_board (
  // clock
  input  wire       pclk,
  // device pad side
  input  wire [5:0] pad_out,
  input  wire [5:0] pad_oe_n,
  input  wire [5:0] pad_pull_en,
  input  wire [5:0] pad_pull_dn,
  // external drivers
  input  wire [5:0] ext_en,
  input  wire [5:0] ext_val,
  output wire [5:0] pad_in
);
  reg [5:0] last_reg = 6'h00;
  // a floating pad never keeps its old level
  assign pad_in = (ext_en & ext_val) | (~ext_en & ~pad_oe_n & pad_out)
                | (~ext_en & pad_oe_n & pad_pull_en & ~pad_pull_dn)
                | (~ext_en & pad_oe_n & ~pad_pull_en & ~last_reg);
  always @(posedge pclk) begin
    last_reg <= pad_in;
  end
endmodule // pfpc_board

// ==== tb_top.sv ====
// self-checking bench for the pin function and pad control block
`timescale 1ns/1ns
`include "pfpc_defines.vh"
module tb_top;
  // apb side
  reg         pclk = 1'b0, presetn, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire        pready, pslverr;
  // port logic and peripherals
  reg  [5:0]  port_dir = 6'h00, port_data = 6'h00;
  reg  [3:0]  kbd_en = 4'h0, kbd_rise = 4'h0, tim1_en = 4'h0, adc_en = 4'h0, ana2_en = 4'h0;
  reg  [1:0]  tim1_out_en = 2'h0, tim1_out = 2'h0;
  reg         tim2_out_en = 1'b0, tim2_out = 1'b0, tim2_cap_en = 1'b0, irq_en = 1'b0, irq_rise = 1'b0;
  reg         bdc_drive_low = 1'b0, bdc_speedup = 1'b0, other_rst_req = 1'b0;
  wire        second_timer_capture_input, irq_level, bdc_bit_tick, background_debug_mode;
  wire        sys_rst_n, clk_internal_sel;
  wire [3:0]  bus_clk_div;
  // pads
  wire [5:0]  port_in, pad_in, pad_out, pad_oe_n, pad_pull_en, pad_pull_dn, pad_slew_en, pad_drive_hi;
  reg  [5:0]  ext_en = 6'h00, ext_val = 6'h00;
  // bench model
  integer     err_count = 0, cmp_count = 0;
  integer     m_pull, m_slew, m_drive, c, d, i;
  reg  [31:0] rd;
  reg         er;

  pfpc_top #(.NPINS(6)) dut (.*);
  pfpc_board board (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
    .pad_pull_dn(pad_pull_dn), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  always #50 pclk = ~pclk;
  ////////////////////////////////////////
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [31:0] a, input [31:0] v);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rchk(input string nm, input [31:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd & m);
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge pclk);
      #1;
    end
  endtask
  task wait_run;
    begin
      c = 0;
      while (sys_rst_n !== 1'b1 && c < 100) begin
        @(posedge pclk);
        c = c + 1;
      end
      chk("run", 1, sys_rst_n);
    end
  endtask
  task por(input ms_low);
    begin
      @(posedge pclk);
      presetn <= 1'b0;
      ext_en[4] <= ms_low;
      ext_val[4] <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      wait_run;
      ext_en[4] <= 1'b0;
    end
  endtask
  task wt;
    begin
      c = 1;
      @(posedge pclk);
      while (bdc_bit_tick !== 1'b1 && c < 40) begin
        @(posedge pclk);
        c = c + 1;
      end
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #(4000 * 100);
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    presetn <= 1'b0;
    i = $urandom(48);
    por(1'b0);
    chk("mode", 0, background_debug_mode);
    rchk("option", `PFPC_OFS_SOPT, 3, 2);
    rchk("pull", `PFPC_OFS_PULL, 63, 0);
    rchk("slew", `PFPC_OFS_SLEW, 63, 16);
    rchk("drive", `PFPC_OFS_DRIVE, 63, 0);
    settle;
    chk("oe_n", 63, pad_oe_n);
    chk("pull_en", 16, pad_pull_en);
    wt;
    wt;
    chk("bit_gap", 16, c);
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    ce <= 1'b1;
    wt;
    chk("ce_hold", 16, c);
    $display("test defaults done");
    for (i = 0; i < 6; i = i + 1) begin
      m_pull = $urandom % 64;
      m_slew = $urandom % 64;
      m_drive = $urandom % 64;
      d = $urandom % 16;
      apb(1'b1, `PFPC_OFS_PULL, m_pull);
      apb(1'b1, `PFPC_OFS_SLEW, m_slew);
      apb(1'b1, `PFPC_OFS_DRIVE, m_drive);
      @(posedge pclk);
      port_dir <= d[5:0];
      port_data <= $urandom % 64;
      settle;
      chk("oe_n", ~d & 15, pad_oe_n[3:0]);
      chk("pull", m_pull & ~d & 15, pad_pull_en[3:0]);
      chk("slew", m_slew & d & 15, pad_slew_en[3:0]);
      chk("drive", m_drive & d & 15, pad_drive_hi[3:0]);
      chk("out", port_data & d & 15, pad_out[3:0] & d[3:0]);
      chk("pull5", m_pull / 32, pad_pull_en[5]);
    end
    $display("test pad control done");
    apb(1'b1, `PFPC_OFS_PULL, 32'h0000_000f);
    @(posedge pclk);
    port_dir <= 6'h09;
    adc_en <= 4'h1;
    ana2_en <= 4'h1;
    tim1_en <= 4'h2;
    tim1_out_en <= 2'h2;
    tim1_out <= 2'h2;
    kbd_en <= 4'h4;
    kbd_rise <= 4'h4;
    settle;
    chk("prio_oe_n", 5, pad_oe_n[3:0]);
    chk("tim_out", 1, pad_out[1]);
    chk("prio_pull", 4, pad_pull_en[3:0]);
    chk("pulldown", 1, pad_pull_dn[2]);
    $display("test priority done");
    apb(1'b1, `PFPC_OFS_SOPT, 32'h0000_0000);
    @(posedge pclk);
    {adc_en, ana2_en, tim1_en, kbd_en} <= 16'h0000;
    tim2_out_en <= 1'b1;
    tim2_out <= 1'b1;
    settle;
    chk("dbg_oe_n", 0, pad_oe_n[4]);
    chk("dbg_out", 1, pad_out[4]);
    chk("dbg_pull", 0, pad_pull_en[4]);
    chk("dbg_slew", (m_slew / 16) % 2, pad_slew_en[4]);
    @(posedge pclk);
    tim2_out_en <= 1'b0;
    ext_en[5] <= 1'b1;
    ext_val[5] <= 1'b1;
    settle;
    chk("port_in5", 1, port_in[5]);
    @(posedge pclk);
    tim2_cap_en <= 1'b1;
    settle;
    chk("capture", 1, second_timer_capture_input);
    @(posedge pclk);
    irq_en <= 1'b1;
    settle;
    chk("irq", 1, irq_level);
    chk("cap_off", 0, second_timer_capture_input);
    @(posedge pclk);
    irq_en <= 1'b0;
    tim2_cap_en <= 1'b0;
    ext_en[5] <= 1'b0;
    $display("test alternates done");
    apb(1'b1, `PFPC_OFS_SOPT, 32'h0000_0001);
    apb(1'b1, `PFPC_OFS_SOPT, 32'h0000_0000);
    rchk("rpe", `PFPC_OFS_SOPT, 3, 1);
    settle;
    chk("rst_pull", 1, pad_pull_en[5]);
    @(posedge pclk);
    ext_en <= 6'h30;
    ext_val <= 6'h00;
    settle;
    chk("pin_rst", 0, sys_rst_n);
    @(posedge pclk);
    ext_en[5] <= 1'b0;
    wait_run;
    chk("pin_mode", 0, background_debug_mode);
    rchk("status", `PFPC_OFS_STATUS, 7, 2);
    rchk("option", `PFPC_OFS_SOPT, 3, 3);
    apb(1'b1, `PFPC_OFS_FRST, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    wait_run;
    chk("frc_mode", 1, background_debug_mode);
    rchk("status", `PFPC_OFS_STATUS, 7, 5);
    rchk("force", `PFPC_OFS_FRST, 1, 0);
    $display("test resets done");
    por(1'b1);
    chk("por_mode", 1, background_debug_mode);
    rchk("option", `PFPC_OFS_SOPT, 3, 3);
    chk("clk", 5'h14, {clk_internal_sel, bus_clk_div});
    apb(1'b0, 32'h0000_0018, 32'h0000_0000);
    chk("slverr", 1, er);
    chk("unmapped", 0, rd);
    $display("test background power-on done");
    test_done;
  end
endmodule // tb_top
